// ==== rtl/igp_pkg.sv ====
package igp_pkg;

  // ---------------------------------------------------------------------
  // Timing figures (ns) and derived cycle counts at 10 MHz
  // ---------------------------------------------------------------------
  localparam int CLK_PERIOD_NS       = 100;
  localparam int GAP_NS              = 3000;
  localparam int MIN_ON_NS           = 1500;
  localparam int MIN_OFF_LO_NS       = 3000;
  localparam int MIN_OFF_HI_NS       = 3500;
  localparam int GAP_CYC             =
    (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_ON_CYC          =
    (MIN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_OFF_LO_CYC      =
    (MIN_OFF_LO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_OFF_HI_CYC      =
    (MIN_OFF_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W               = 6;
  localparam int PHASES              = 3;

  // ---------------------------------------------------------------------
  // Per-switch state
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    IGP_OFF,
    IGP_ON
  } igp_sw_t;

endpackage

// ==== rtl/igp_leg_if.sv ====
`timescale 1ns/1ps
interface igp_leg_if;
  logic hi_req;
  logic lo_req;
  logic kill;
  logic heavy;
  logic hi_cmd;
  logic lo_cmd;

  modport ctrl (input hi_req, lo_req, kill, heavy, output hi_cmd, lo_cmd);
  modport top  (output hi_req, lo_req, kill, heavy, input hi_cmd, lo_cmd);
endinterface

// ==== rtl/igp_leg.sv ====
`timescale 1ns/1ps
module igp_leg
  import igp_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset,
  // Leg requests and commands
  igp_leg_if.ctrl   leg
);
  import igp_pkg::*;

  // Counters must reach the longest off time
  if (2 ** CNT_W - 1 <= MIN_OFF_HI_CYC) begin : g_bad_cnt_w
    $error("CNT_W too narrow for the timing counts");
  end

  igp_sw_t               hs_r, hs_nxt, ls_r, ls_nxt;
  logic [CNT_W-1:0]      hc_r, hc_nxt, lc_r, lc_nxt, gap_r, gap_nxt;

  // ---------------------------------------------------------------------
  // Leg sequencer: min on, min off, shoot-through gap
  // ---------------------------------------------------------------------
  function automatic logic [CNT_W-1:0] sat(input logic [CNT_W-1:0] v);
    sat = (v == '1) ? v : v + 6'h01;
  endfunction

  always_comb begin
    logic [CNT_W-1:0] off_min;
    off_min = leg.heavy ? CNT_W'(MIN_OFF_HI_CYC)
                        : CNT_W'(MIN_OFF_LO_CYC);
    hs_nxt  = hs_r;
    ls_nxt  = ls_r;
    hc_nxt  = sat(hc_r);
    lc_nxt  = sat(lc_r);
    gap_nxt = sat(gap_r);
    unique case (hs_r)
      IGP_ON: begin
        if (leg.kill || (!leg.hi_req && hc_r >= CNT_W'(MIN_ON_CYC))) begin
          hs_nxt  = IGP_OFF;
          hc_nxt  = '0;
          gap_nxt = '0;
        end
      end
      IGP_OFF: begin
        if (!leg.kill && leg.hi_req && ls_r == IGP_OFF &&
            gap_r >= CNT_W'(GAP_CYC) && hc_r >= off_min) begin
          hs_nxt = IGP_ON;
          hc_nxt = '0;
        end
      end
    endcase
    unique case (ls_r)
      IGP_ON: begin
        if (leg.kill || (!leg.lo_req && lc_r >= CNT_W'(MIN_ON_CYC))) begin
          ls_nxt  = IGP_OFF;
          lc_nxt  = '0;
          gap_nxt = '0;
        end
      end
      IGP_OFF: begin
        if (!leg.kill && leg.lo_req && hs_r == IGP_OFF &&
            hs_nxt == IGP_OFF && !leg.hi_req &&
            gap_r >= CNT_W'(GAP_CYC) && lc_r >= off_min) begin
          ls_nxt = IGP_ON;
          lc_nxt = '0;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      hs_r  <= IGP_OFF;
      ls_r  <= IGP_OFF;
      hc_r  <= '1;
      lc_r  <= '1;
      gap_r <= '1;
    end else begin
      hs_r  <= hs_nxt;
      ls_r  <= ls_nxt;
      hc_r  <= hc_nxt;
      lc_r  <= lc_nxt;
      gap_r <= gap_nxt;
    end
  end

  assign leg.hi_cmd = (hs_r == IGP_ON);
  assign leg.lo_cmd = (ls_r == IGP_ON);

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  // Run lengths of each command, counted apart from the sequencer
  logic [CNT_W-1:0]      hi_on_n_r, hi_on_n_nxt, lo_on_n_r, lo_on_n_nxt;
  logic [CNT_W-1:0]      hi_off_n_r, hi_off_n_nxt, lo_off_n_r, lo_off_n_nxt;

  always_comb begin
    hi_on_n_nxt  = leg.hi_cmd ? sat(hi_on_n_r) : '0;
    lo_on_n_nxt  = leg.lo_cmd ? sat(lo_on_n_r) : '0;
    hi_off_n_nxt = leg.hi_cmd ? '0 : sat(hi_off_n_r);
    lo_off_n_nxt = leg.lo_cmd ? '0 : sat(lo_off_n_r);
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      hi_on_n_r  <= '0;
      lo_on_n_r  <= '0;
      hi_off_n_r <= '1;
      lo_off_n_r <= '1;
    end else begin
      hi_on_n_r  <= hi_on_n_nxt;
      lo_on_n_r  <= lo_on_n_nxt;
      hi_off_n_r <= hi_off_n_nxt;
      lo_off_n_r <= lo_off_n_nxt;
    end
  end

  a_leg_no_overlap: assert property (
    @(posedge clk_sys) disable iff (reset)
    !(leg.hi_cmd && leg.lo_cmd))
    else $error("both switches of a leg on");
  a_gap_hi_to_lo: assert property (
    @(posedge clk_sys) disable iff (reset)
    $rose(leg.lo_cmd) |-> hi_off_n_r >= GAP_CYC)
    else $error("gap after high side too short");
  a_gap_lo_to_hi: assert property (
    @(posedge clk_sys) disable iff (reset)
    $rose(leg.hi_cmd) |-> lo_off_n_r >= GAP_CYC)
    else $error("gap after low side too short");
  a_on_width: assert property (
    @(posedge clk_sys) disable iff (reset)
    $fell(leg.hi_cmd) && !$past(leg.kill) |-> hi_on_n_r >= MIN_ON_CYC)
    else $error("on pulse too short");
  a_on_width_lo: assert property (
    @(posedge clk_sys) disable iff (reset)
    $fell(leg.lo_cmd) && !$past(leg.kill) |-> lo_on_n_r >= MIN_ON_CYC)
    else $error("low side on pulse too short");
  a_off_width: assert property (
    @(posedge clk_sys) disable iff (reset)
    $rose(leg.lo_cmd) |->
      lo_off_n_r >= ($past(leg.heavy) ? MIN_OFF_HI_CYC : MIN_OFF_LO_CYC))
    else $error("off interval too short");
  a_off_width_hi: assert property (
    @(posedge clk_sys) disable iff (reset)
    $rose(leg.hi_cmd) |->
      hi_off_n_r >= ($past(leg.heavy) ? MIN_OFF_HI_CYC : MIN_OFF_LO_CYC))
    else $error("high side off interval too short");
  c_leg_hi: cover property (@(posedge clk_sys) $rose(leg.hi_cmd));
  c_leg_lo: cover property (@(posedge clk_sys) $rose(leg.lo_cmd));
endmodule

// ==== rtl/igp_ctrl.sv ====
`timescale 1ns/1ps
// Contract
// - Keep 3.0 us gap between leg switches
// - On pulses last at least 1.5 us; a kill from the latched fault or a low fault line cuts them short
// - Off intervals 3.0 us, 3.5 us heavy current
// - Open-drain fault line, low means fault
module igp_ctrl
  import igp_pkg::*;
#(
  parameter int PHASES_P = PHASES
)(
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                reset,
  // PWM requests from the modulator
  input  wire logic [PHASES_P-1:0] pwm_hi_req,
  input  wire logic [PHASES_P-1:0] pwm_lo_req,
  input  wire logic                heavy_current,
  // Software recovery
  input  wire logic                restart,
  output logic                     fault_latched,
  output logic                     fault_event,
  // Gate inputs of the module
  output logic [PHASES_P-1:0]      gate_hi,
  output logic [PHASES_P-1:0]      gate_lo,
  // Open-drain fault line
  input  wire logic                fault_out_in,
  output logic                     fault_out_o,
  output logic                     fault_out_oe
);
  import igp_pkg::*;

  if (PHASES_P < 1 || PHASES_P > 8) begin : g_bad_phases
    $error("PHASES_P out of range");
  end

  // ---------------------------------------------------------------------
  // Fault line sync and event capture
  // ---------------------------------------------------------------------
  logic fo_s1_r, fo_s2_r, fo_s3_r;
  logic lat_r, lat_nxt;
  logic fault_now, fault_edge;

  // Line only sensed, never driven low by the host
  assign fault_out_o  = 1'b0;
  assign fault_out_oe = 1'b0;
  assign fault_now    = !fo_s2_r;
  assign fault_edge   = fo_s3_r && !fo_s2_r;

  always_comb begin
    lat_nxt = lat_r;
    if (restart && !fault_now)
      lat_nxt = 1'b0;
    if (fault_edge)
      lat_nxt = 1'b1;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      fo_s1_r <= 1'b1;
      fo_s2_r <= 1'b1;
      fo_s3_r <= 1'b1;
      lat_r   <= 1'b0;
    end else begin
      fo_s1_r <= fault_out_in;
      fo_s2_r <= fo_s1_r;
      fo_s3_r <= fo_s2_r;
      lat_r   <= lat_nxt;
    end
  end

  assign fault_latched = lat_r;
  assign fault_event   = fault_edge;

  // ---------------------------------------------------------------------
  // Legs
  // ---------------------------------------------------------------------
  logic kill;
  // A reported trip or undervolt means the device needs a fresh
  // low-to-high edge to re-arm; holding all gates low gives it one
  // later, on restart.
  assign kill = lat_r || fault_now;

  for (genvar p = 0; p < PHASES_P; p++) begin : g_leg
    igp_leg_if leg ();
    assign leg.hi_req = pwm_hi_req[p];
    assign leg.lo_req = pwm_lo_req[p];
    assign leg.kill   = kill;
    assign leg.heavy  = heavy_current;
    igp_leg u_leg (
      .clk_sys (clk_sys),
      .reset   (reset),
      .leg     (leg.ctrl)
    );
    assign gate_hi[p] = leg.hi_cmd;
    assign gate_lo[p] = leg.lo_cmd;
  end

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  a_fault_gates_low: assert property (
    @(posedge clk_sys) disable iff (reset)
    lat_r |=> (gate_hi == '0 && gate_lo == '0))
    else $error("gates driven while fault latched");
  a_line_low_gates: assert property (
    @(posedge clk_sys) disable iff (reset)
    fault_now |=> (gate_hi == '0 && gate_lo == '0))
    else $error("gates driven while fault line low");
  a_fault_latches: assert property (
    @(posedge clk_sys) disable iff (reset)
    $fell(fo_s2_r) |=> lat_r)
    else $error("fault edge not latched");
  a_line_released: assert property (
    @(posedge clk_sys) disable iff (reset)
    !fault_out_oe)
    else $error("host drives fault line");
  a_latch_holds: assert property (
    @(posedge clk_sys) disable iff (reset)
    lat_r && !restart |=> lat_r)
    else $error("fault latch dropped without restart");
  c_fault_seen: cover property (@(posedge clk_sys) $rose(lat_r));
  c_restart: cover property (@(posedge clk_sys) $fell(lat_r));
  c_run: cover property (@(posedge clk_sys) gate_lo != '0);
endmodule

// ==== tb/igp_dev_model.sv ====
`timescale 1ns/1ps
module igp_dev_model #(
  parameter int PULSE_CYC = 20
)(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // Gate inputs and protection stimulus
  input  wire logic [2:0] gate_hi,
  input  wire logic [2:0] gate_lo,
  input  wire logic       short_circuit_trip,
  input  wire logic       low_uv,
  input  wire logic [2:0] high_uv,
  // Switch states and fault pull-down
  output logic [2:0]      sw_hi,
  output logic [2:0]      sw_lo,
  output logic            fault_pull
);
  logic [2:0] arm_hi_r;
  logic [2:0] arm_lo_r;
  logic [2:0] prev_hi_r;
  logic [2:0] prev_lo_r;
  int         pulse_cnt_r;
  logic       kill_lo;
  // ----------------------------------------------------------------
  // Switches and fault line
  // ----------------------------------------------------------------
  assign kill_lo = short_circuit_trip | low_uv;
  assign sw_lo = gate_lo & arm_lo_r & {3{~kill_lo}};
  assign sw_hi = gate_hi & arm_hi_r & ~high_uv;
  assign fault_pull = (pulse_cnt_r != 0) | low_uv;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      arm_hi_r    <= 3'h7;
      arm_lo_r    <= 3'h7;
      prev_hi_r   <= 3'h0;
      prev_lo_r   <= 3'h0;
      pulse_cnt_r <= 0;
    end else begin
      prev_hi_r <= gate_hi;
      prev_lo_r <= gate_lo;
      arm_hi_r  <= (arm_hi_r | (gate_hi & ~prev_hi_r)) & ~high_uv;
      arm_lo_r  <= kill_lo ? 3'h0 : arm_lo_r | (gate_lo & ~prev_lo_r);
      if (kill_lo) begin
        pulse_cnt_r <= PULSE_CYC;
      end else if (pulse_cnt_r != 0) begin
        pulse_cnt_r <= pulse_cnt_r - 1;
      end
    end
  end
endmodule

// ==== tb/inverter_gate_protection_bench.sv ====
`timescale 1ns/1ps
module inverter_gate_protection_bench;
  import igp_pkg::*;
  localparam int PULSE_CYC = 20;
  logic       clk_sys;
  logic       reset;
  logic [2:0] pwm_hi_req;
  logic [2:0] pwm_lo_req;
  logic       heavy_current;
  logic       restart;
  logic       sc;
  logic       low_uv;
  logic [2:0] high_uv;
  logic       fault_latched;
  logic       fault_event;
  logic [2:0] gate_hi;
  logic [2:0] gate_lo;
  logic       fault_out_o;
  logic       fault_out_oe;
  logic       fault_pull;
  logic       fault_line;
  logic [2:0] sw_hi;
  logic [2:0] sw_lo;
  int         mismatches;
  int         n_checks;
  int         cyc;
  time        t0;
  time        t1;
  time        t2;
  // ----------------------------------------------------------------
  // Instances, clock, limit
  // ----------------------------------------------------------------
  // Pull-up unless either party sinks the line
  assign fault_line = ~(fault_pull | (fault_out_oe & ~fault_out_o));
  igp_ctrl #(.PHASES_P(3)) dut_u (.clk_sys(clk_sys), .reset(reset),
    .pwm_hi_req(pwm_hi_req), .pwm_lo_req(pwm_lo_req),
    .heavy_current(heavy_current), .restart(restart),
    .fault_latched(fault_latched), .fault_event(fault_event),
    .gate_hi(gate_hi), .gate_lo(gate_lo), .fault_out_in(fault_line),
    .fault_out_o(fault_out_o), .fault_out_oe(fault_out_oe));
  igp_dev_model #(.PULSE_CYC(PULSE_CYC)) dev_u (.clk_sys(clk_sys),
    .reset(reset), .gate_hi(gate_hi), .gate_lo(gate_lo),
    .short_circuit_trip(sc), .low_uv(low_uv), .high_uv(high_uv),
    .sw_hi(sw_hi), .sw_lo(sw_lo), .fault_pull(fault_pull));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input bit ok, input string msg);
    n_checks++;
    if (!ok) begin
      mismatches++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask
  task automatic wait_gate(input bit hi, input int ph, input logic v,
                           output time t);
    int n;
    n = 0;
    while ((hi ? gate_hi[ph] : gate_lo[ph]) !== v && n < 300) begin
      tick();
      n++;
    end
    chk(n < 300, "gate stuck");
    t = $time;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_on_gap;
    pwm_lo_req[0] = 1'b1;
    t0 = $time;
    wait_gate(0, 0, 1'b1, t1);
    chk(t1 - t0 <= 2 * CLK_PERIOD_NS, "slow turn-on");
    pwm_lo_req[0] = 1'b0;
    pwm_hi_req[0] = 1'b1;
    wait_gate(0, 0, 1'b0, t2);
    chk(t2 - t1 >= MIN_ON_NS, "on pulse short");
    wait_gate(1, 0, 1'b1, t0);
    chk(t0 - t2 >= GAP_NS && gate_lo[0] === 1'b0, "gap short");
    $display("test on_gap done");
  endtask
  task automatic t_high_uv;
    high_uv[0] = 1'b1;
    for (int i = 0; i < 20; i++) begin
      tick();
      chk(fault_event === 1'b0 && fault_latched === 1'b0, "fault");
    end
    high_uv[0] = 1'b0;
    pwm_hi_req[0] = 1'b0;
    $display("test high_uv done");
  endtask
  task automatic t_min_off;
    for (int h = 0; h < 2; h++) begin
      heavy_current = h[0];
      pwm_lo_req[1] = 1'b1;
      wait_gate(0, 1, 1'b1, t0);
      pwm_lo_req[1] = 1'b0;
      wait_gate(0, 1, 1'b0, t1);
      pwm_lo_req[1] = 1'b1;
      wait_gate(0, 1, 1'b1, t2);
      t0 = h ? MIN_OFF_HI_NS : MIN_OFF_LO_NS;
      chk(t2 - t1 >= t0, "off short");
      pwm_lo_req[1] = 1'b0;
      wait_gate(0, 1, 1'b0, t0);
    end
    $display("test min_off done");
  endtask
  task automatic t_fault(input bit uv);
    int ev;
    ev = 0;
    pwm_lo_req = 3'h4;
    pwm_hi_req = 3'h2;
    wait_gate(1, 1, 1'b1, t0);
    sc = ~uv;
    low_uv = uv;
    tick();
    sc = 1'b0;
    for (int i = 0; i < 6; i++) begin
      tick();
      ev += (fault_event === 1'b1);
    end
    chk(ev == 1 && fault_latched === 1'b1, "no event");
    chk(gate_lo === 3'h0 && gate_hi === 3'h0, "gates on");
    tick(PULSE_CYC + 30);
    low_uv = 1'b0;
    // Fault pulse outlasts the undervolt by its fixed width
    tick(PULSE_CYC + 5);
    chk(gate_lo === 3'h0 && gate_hi === 3'h0, "gates on");
    pwm_lo_req = 3'h0;
    pwm_hi_req = 3'h0;
    restart = 1'b1;
    tick();
    restart = 1'b0;
    tick();
    chk(fault_latched === 1'b0, "latch stuck");
    pwm_lo_req = 3'h4;
    wait_gate(0, 2, 1'b1, t0);
    tick();
    chk(sw_lo[2] === 1'b1, "no re-arm on fresh edge");
    pwm_lo_req = 3'h0;
    wait_gate(0, 2, 1'b0, t0);
    $display("test fault done");
  endtask
  initial begin
    {reset, restart, sc, low_uv, heavy_current} = 5'h10;
    {pwm_hi_req, pwm_lo_req, high_uv} = 9'h000;
    mismatches = 0;
    n_checks = 0;
    cyc = 0;
    tick(16);
    reset = 1'b0;
    tick();
    t_on_gap();
    t_high_uv();
    t_min_off();
    t_fault(1'b0);
    t_fault(1'b1);
    give_verdict();
  end
endmodule
